// *** design/saf_top.sv ***
// saf_top: security attribution and access filter for core, transfer engines,
// ethernet master and peripherals, with an axi4-lite register slave
// assumes: masters hold a request for one cycle and act on grant/deny pulses
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "saf_map.svh"
module saf_top
  import saf_pkg::*;
#(
  parameter int N_REG = 8,
  parameter int DMA_CH = 8,
  parameter int PER_CH = 32,
  parameter int N_MST = 4
)
(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic sec_ext_present, // security extension strap
  input wire logic lifecycle_ssd, // lifecycle in secure development
  input wire logic cpu_to_ns, // core switches to non-secure
  input wire logic cpu_to_s, // core switches to secure
  input wire saf_prog_type prog_cmd, // serial region programming
  input wire saf_req_type cpu_req, // core access
  input wire saf_req_type dma_req, // dma access, ch = channel
  input wire saf_req_type dtc_req, // transfer controller access
  input wire saf_req_type eth_req, // ethernet master access
  input wire logic dma_start_req, // request to start the dma
  input wire logic dma_start_ns, // start request from non-secure code
  input wire logic pe_entry_req, // program/erase entry attempt
  input wire logic pe_entry_ns, // attempt from non-secure code
  input wire saf_req_type per_req, // peripheral access, ch = channel
  input wire logic [31:0] per_rdata_in, // peripheral read data
  output logic prog_done, // region written
  output logic prog_refused, // programming refused
  output logic cpu_secure, // core security state
  output saf_ans_type cpu_ans, // core answer
  output saf_ans_type dma_ans, // dma answer
  output saf_ans_type dtc_ans, // transfer controller answer
  output saf_ans_type eth_ans, // ethernet answer
  output logic dma_start_ok, // dma start accepted
  output logic transfer_error_irq, // transfer error interrupt pulse
  output logic pe_entry_ok, // program/erase entry granted
  output logic secure_fault_rst, // secure fault as reset request
  output logic secure_fault_nmi, // secure fault as nmi
  output logic per_allow, // peripheral access passes
  output logic per_access_error, // peripheral access error pulse
  output logic [31:0] per_rdata, // gated read data
  output logic [N_MST-1:0] bmpu_attr, // master protection attributes
  input wire logic [7:0] awaddr, // axi write address
  input wire logic [2:0] awprot, // axi write protection
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi write strobes
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  output logic [1:0] bresp, // axi write response
  output logic bvalid, // axi write response valid
  input wire logic bready, // axi write response ready
  input wire logic [7:0] araddr, // axi read address
  input wire logic [2:0] arprot, // axi read protection
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp, // axi read response
  output logic rvalid, // axi read valid
  input wire logic rready // axi read ready
);

  generate
    if (N_REG < 1 || N_REG > 8 || DMA_CH < 1 || DMA_CH > 32 || PER_CH != 32 ||
        N_MST < 1 || N_MST > 32)
    begin : g_bad_param
      $error("saf_top: unsupported parameter values");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else if (ce)
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  saf_region_type regions [N_REG];
  logic [31:0] ctrl;
  logic [31:0] status_bits;
  logic [31:0] dma_attr;
  logic [31:0] per_attr;
  logic [31:0] bmpu_reg;
  logic [31:0] fine_attr;
  logic strap_done;
  logic ext_present;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr_q;
  logic aw_ns_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // ----------------------------------------------------------------------
  // region lookups, one table for every master
  // ----------------------------------------------------------------------
  logic cpu_viol;
  logic dma_viol;
  logic dtc_viol;
  logic eth_viol;
  wire cpu_ns = ~cpu_secure;
  wire dma_ch_ns = ~dma_attr[dma_req.ch];

  saf_region_check #(.N_REG(N_REG)) u_chk_cpu (
    .table_in(regions),
    .addr(cpu_req.addr),
    .ns(cpu_ns),
    .violation(cpu_viol)
  );
  saf_region_check #(.N_REG(N_REG)) u_chk_dma (
    .table_in(regions),
    .addr(dma_req.addr),
    .ns(dma_ch_ns),
    .violation(dma_viol)
  );
  saf_region_check #(.N_REG(N_REG)) u_chk_dtc (
    .table_in(regions),
    .addr(dtc_req.addr),
    .ns(dtc_req.ns),
    .violation(dtc_viol)
  );
  // ethernet master carries no attribute of its own: always non-secure
  saf_region_check #(.N_REG(N_REG)) u_chk_eth (
    .table_in(regions),
    .addr(eth_req.addr),
    .ns(1'b1),
    .violation(eth_viol)
  );

  // ----------------------------------------------------------------------
  // decisions
  // ----------------------------------------------------------------------
  wire cpu_block = cpu_req.valid && cpu_viol;
  wire dma_block = dma_req.valid && dma_viol;
  wire dtc_block = dtc_req.valid && dtc_viol;
  wire eth_block = eth_req.valid && eth_viol;
  wire filter_hit = dma_block || dtc_block || eth_block;
  wire fault_nmi_sel = ctrl[`SAF_CTRL_FAULT_NMI];
  wire pe_refuse = pe_entry_req && pe_entry_ns && !ctrl[`SAF_CTRL_PE_NS];
  wire start_refuse = dma_start_ns && !ctrl[`SAF_CTRL_DMA_START_NS];
  wire prog_ok = prog_cmd.valid && lifecycle_ssd;

  wire [31:0] per_sec = per_attr & ~`SAF_ALWAYS_NS_MASK;
  wire per_chan_sec = per_sec[per_req.ch];
  wire per_fine_sec = fine_attr[per_req.ch];
  wire per_target_sec = per_req.fine ? per_fine_sec : per_chan_sec;
  wire per_block = per_req.valid && per_req.ns && per_target_sec;

  // ----------------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------------
  wire wr_fire = aw_full && w_full && !bvalid;
  wire rd_fire = arvalid && arready;
  wire wr_ctrl = aw_addr_q == `SAF_OFS_CTRL;
  wire wr_status = aw_addr_q == `SAF_OFS_STATUS;
  wire wr_dma = aw_addr_q == `SAF_OFS_DMA_ATTR;
  wire wr_per = aw_addr_q == `SAF_OFS_PER_ATTR;
  wire wr_bmpu = aw_addr_q == `SAF_OFS_BMPU_ATTR;
  wire wr_fine = aw_addr_q == `SAF_OFS_FINE_ATTR;
  wire wr_known = wr_ctrl || wr_status || wr_dma || wr_per || wr_bmpu || wr_fine;
  // all but the status register only take secure writes
  wire wr_sec_only = wr_known && !wr_status;
  wire wr_denied = wr_sec_only && aw_ns_q;
  wire wr_do = wr_fire && wr_known && !wr_denied;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] w_clear = (wr_do && wr_status) ? (w_data_q & wmask & `SAF_ST_W1C_MASK) : 32'h0;

  wire [31:0] status_view = {27'h0, cpu_secure, status_bits[3:0]};
  wire rd_ctrl = araddr == `SAF_OFS_CTRL;
  wire rd_status = araddr == `SAF_OFS_STATUS;
  wire rd_dma = araddr == `SAF_OFS_DMA_ATTR;
  wire rd_per = araddr == `SAF_OFS_PER_ATTR;
  wire rd_bmpu = araddr == `SAF_OFS_BMPU_ATTR;
  wire rd_fine = araddr == `SAF_OFS_FINE_ATTR;
  wire rd_known = rd_ctrl || rd_status || rd_dma || rd_per || rd_bmpu || rd_fine;
  wire [31:0] rd_mux = rd_ctrl ? ctrl :
                       rd_status ? status_view :
                       rd_dma ? dma_attr :
                       rd_per ? per_sec :
                       rd_bmpu ? bmpu_reg :
                       rd_fine ? fine_attr : 32'h0;

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  logic next_aw_full;
  logic next_w_full;
  logic next_bvalid;
  logic next_rvalid;
  logic [31:0] set_bits;

  always_comb
  begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_bvalid = bvalid;
    next_rvalid = rvalid;
    if (awvalid && awready)
      next_aw_full = 1'b1;
    if (wvalid && wready)
      next_w_full = 1'b1;
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (rd_fire)
      next_rvalid = 1'b1;
    set_bits = 32'h0;
    set_bits[`SAF_ST_PE_ERR] = pe_refuse;
    set_bits[`SAF_ST_FILTER_ERR] = filter_hit;
    set_bits[`SAF_ST_ACCESS_ERR] = per_block;
    set_bits[`SAF_ST_SEC_FAULT] = cpu_block;
  end

  // ----------------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------------
  // the strap is caught on the first enabled edge after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done <= 1'b0;
      ext_present <= 1'b0;
      cpu_secure <= 1'b0;
    end
    else if (ce)
    begin
      strap_done <= 1'b1;
      if (!strap_done)
      begin
        ext_present <= sec_ext_present;
        cpu_secure <= sec_ext_present;
      end
      else if (!ext_present)
        cpu_secure <= 1'b0;
      else if (cpu_to_ns)
        cpu_secure <= 1'b0;
      else if (cpu_to_s)
        cpu_secure <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // region table
  // ----------------------------------------------------------------------
  // stands in for the nonvolatile copy; reset leaves every region unused
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < N_REG; i++)
      begin
        regions[i] <= '{base: `SAF_REGION_BASE_RESET, limit: `SAF_REGION_LIMIT_RESET,
                        attr: SAF_ATTR_NS};
      end
      prog_done <= 1'b0;
      prog_refused <= 1'b0;
    end
    else if (ce)
    begin
      if (prog_ok)
        regions[prog_cmd.index] <= prog_cmd.region;
      prog_done <= prog_ok;
      prog_refused <= prog_cmd.valid && !lifecycle_ssd;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `SAF_CTRL_RESET;
      status_bits <= 32'h0;
      dma_attr <= `SAF_ATTR_RESET;
      per_attr <= `SAF_ATTR_RESET;
      bmpu_reg <= `SAF_ATTR_RESET;
      fine_attr <= `SAF_ATTR_RESET;
    end
    else if (ce)
    begin
      // a fresh event outlasts a clear in the same cycle
      status_bits <= (status_bits & ~w_clear) | set_bits;
      if (wr_do && wr_ctrl)
        ctrl <= (ctrl & ~wmask) | (w_data_q & wmask);
      if (wr_do && wr_dma)
        dma_attr <= (dma_attr & ~wmask) | (w_data_q & wmask);
      if (wr_do && wr_per)
        per_attr <= (per_attr & ~wmask) | (w_data_q & wmask);
      if (wr_do && wr_bmpu)
        bmpu_reg <= (bmpu_reg & ~wmask) | (w_data_q & wmask);
      if (wr_do && wr_fine)
        fine_attr <= (fine_attr & ~wmask) | (w_data_q & wmask);
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= 8'h00;
      aw_ns_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0;
    end
    else if (ce)
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      awready <= !next_aw_full && !next_bvalid;
      wready <= !next_w_full && !next_bvalid;
      arready <= !next_rvalid;
      if (awvalid && awready)
      begin
        aw_addr_q <= awaddr;
        aw_ns_q <= awprot[1];
      end
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
        bresp <= !wr_known ? SAF_RESP_DECERR : (wr_denied ? SAF_RESP_SLVERR : SAF_RESP_OKAY);
      if (rd_fire)
      begin
        rdata <= rd_mux;
        rresp <= rd_known ? SAF_RESP_OKAY : SAF_RESP_DECERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // answers to masters and peripherals
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_ans <= '0;
      dma_ans <= '0;
      dtc_ans <= '0;
      eth_ans <= '0;
      dma_start_ok <= 1'b0;
      transfer_error_irq <= 1'b0;
      pe_entry_ok <= 1'b0;
      secure_fault_rst <= 1'b0;
      secure_fault_nmi <= 1'b0;
      per_allow <= 1'b0;
      per_access_error <= 1'b0;
      per_rdata <= 32'h0;
      bmpu_attr <= '0;
    end
    else if (ce)
    begin
      cpu_ans <= '{grant: cpu_req.valid && !cpu_viol, deny: cpu_block};
      dma_ans <= '{grant: dma_req.valid && !dma_viol, deny: dma_block};
      dtc_ans <= '{grant: dtc_req.valid && !dtc_viol, deny: dtc_block};
      eth_ans <= '{grant: eth_req.valid && !eth_viol, deny: eth_block};
      dma_start_ok <= dma_start_req && !start_refuse;
      transfer_error_irq <= filter_hit;
      pe_entry_ok <= pe_entry_req && !pe_refuse;
      secure_fault_rst <= cpu_block && !fault_nmi_sel;
      secure_fault_nmi <= cpu_block && fault_nmi_sel;
      per_allow <= per_req.valid && !per_block;
      per_access_error <= per_block;
      // blocked or idle cycles show zero so nothing leaks
      per_rdata <= (per_req.valid && !per_req.write && !per_block) ? per_rdata_in : 32'h0;
      bmpu_attr <= bmpu_reg[N_MST-1:0];
    end
  end

endmodule // saf_top

// *** design/saf_map.svh ***
// saf_map.svh: offsets, fields, reset values and fixed maps of the access filter
// assumes: included by bare name from the top module
`ifndef SAF_MAP_SVH
`define SAF_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SAF_OFS_CTRL 8'h00
`define SAF_OFS_STATUS 8'h04
`define SAF_OFS_DMA_ATTR 8'h08
`define SAF_OFS_PER_ATTR 8'h0c
`define SAF_OFS_BMPU_ATTR 8'h10
`define SAF_OFS_FINE_ATTR 8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SAF_CTRL_PE_NS 0
`define SAF_CTRL_FAULT_NMI 1
`define SAF_CTRL_DMA_START_NS 2
`define SAF_ST_PE_ERR 0
`define SAF_ST_FILTER_ERR 1
`define SAF_ST_ACCESS_ERR 2
`define SAF_ST_SEC_FAULT 3
`define SAF_ST_CPU_SECURE 4
`define SAF_ST_W1C_MASK 32'h0000000f

// ----------------------------------------------------------------------
// reset values and fixed maps
// ----------------------------------------------------------------------
`define SAF_CTRL_RESET 32'h00000000
`define SAF_ATTR_RESET 32'h00000000
`define SAF_ALWAYS_NS_MASK 32'hf8000000
`define SAF_REGION_BASE_RESET 32'hffffffff
`define SAF_REGION_LIMIT_RESET 32'h00000000

`endif

// *** design/saf_pkg.sv ***
// saf_pkg: types shared by the access filter modules
// assumes: saf_map.svh supplies the numeric constants
package saf_pkg;

  typedef enum logic [1:0] {
    SAF_ATTR_S = 2'b00,
    SAF_ATTR_NSC = 2'b01,
    SAF_ATTR_NS = 2'b10
  } saf_attr_type;

  typedef enum logic [1:0] {
    SAF_RESP_OKAY = 2'b00,
    SAF_RESP_SLVERR = 2'b10,
    SAF_RESP_DECERR = 2'b11
  } saf_resp_type;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
    saf_attr_type attr;
  } saf_region_type;

  // one access request from a master or to a peripheral
  typedef struct packed {
    logic valid;
    logic write;
    logic ns;
    logic [4:0] ch;
    logic fine;
    logic [31:0] addr;
  } saf_req_type;

  typedef struct packed {
    logic grant;
    logic deny;
  } saf_ans_type;

  // region table programming command
  typedef struct packed {
    logic valid;
    logic [2:0] index;
    saf_region_type region;
  } saf_prog_type;

endpackage

// *** design/saf_region_check.sv ***
// saf_region_check: looks one address up in the shared region table
// assumes: table entries are stable during the lookup; lowest index wins
`timescale 1ns/1ps
module saf_region_check
  import saf_pkg::*;
#(
  parameter int N_REG = 8
)
(
  input wire saf_region_type table_in [N_REG], // shared region table
  input wire logic [31:0] addr, // address under check
  input wire logic ns, // access made non-secure
  output logic violation // non-secure access hits secure or gateway
);

  logic hit_found;
  saf_attr_type hit_attr;

  always_comb
  begin
    hit_found = 1'b0;
    hit_attr = SAF_ATTR_NS;
    for (int i = N_REG - 1; i >= 0; i--)
    begin
      if ((addr >= table_in[i].base) && (addr <= table_in[i].limit))
      begin
        hit_found = 1'b1;
        hit_attr = table_in[i].attr;
      end
    end
  end

  // uncovered addresses count as non-secure
  assign violation = ns && hit_found && (hit_attr != SAF_ATTR_NS);

endmodule // saf_region_check

// *** test/saf_top_checker.sv ***
// saf_top_checker: port-level timing checks of the access filter
// assumes: bound to saf_top, ce held high by the bench
`timescale 1ns/1ps
module saf_top_checker
  import saf_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset
  input wire logic sec_ext_present, // extension strap
  input wire logic cpu_secure, // core state
  input wire saf_req_type dma_req, // dma request
  input wire saf_ans_type dma_ans, // dma answer
  input wire saf_req_type eth_req, // ethernet request
  input wire saf_ans_type eth_ans, // ethernet answer
  input wire logic transfer_error_irq, // transfer error pulse
  input wire logic pe_entry_req, // pe attempt
  input wire logic pe_entry_ns, // attempt origin
  input wire logic pe_entry_ok, // pe granted
  input wire saf_req_type per_req, // peripheral access
  input wire logic per_allow, // access passes
  input wire logic per_access_error, // access refused
  input wire logic [31:0] per_rdata // gated read data
);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_boot; $rose(rstn) |-> ##[2:3] (cpu_secure == sec_ext_present); endproperty
  a_boot: assert property (p_boot) else $error("core state after reset");
  property p_dma_ans; dma_req.valid |=> (dma_ans.grant ^ dma_ans.deny); endproperty
  a_dma_ans: assert property (p_dma_ans) else $error("dma answer missing");
  property p_irq; dma_ans.deny |-> transfer_error_irq; endproperty
  a_irq: assert property (p_irq) else $error("deny without irq");
  property p_eth; eth_req.valid |=> (eth_ans.grant ^ eth_ans.deny); endproperty
  a_eth: assert property (p_eth) else $error("eth answer missing");
  property p_pe_s; pe_entry_req && !pe_entry_ns |=> pe_entry_ok; endproperty
  a_pe_s: assert property (p_pe_s) else $error("secure pe refused");
  property p_per_s; per_req.valid && !per_req.ns |=> per_allow && !per_access_error; endproperty
  a_per_s: assert property (p_per_s) else $error("secure access refused");
  property p_per_ex; per_access_error |-> !per_allow; endproperty
  a_per_ex: assert property (p_per_ex) else $error("error with allow");
  property p_zero; per_rdata != 32'h0 |-> per_allow; endproperty
  a_zero: assert property (p_zero) else $error("data leaked");
endmodule // saf_top_checker

// *** test/saf_tb_master.sv ***
// saf_tb_master: behavioural masters issuing one-cycle requests
// assumes: the bench holds cmd valid for one cycle
`timescale 1ns/1ps
module saf_tb_master
  import saf_pkg::*;
(
  input wire logic clk, // system clock
  input wire saf_req_type cmd, // request to issue
  input wire logic [1:0] sel, // 0 core, 1 dma, 2 dtc, 3 eth
  output saf_req_type cpu_q, // core request
  output saf_req_type dma_q, // dma request
  output saf_req_type dtc_q, // dtc request
  output saf_req_type eth_q // ethernet request
);
  saf_req_type idle;
  // idle lines show inverted data, not the last value
  assign idle = {1'b0, ~cmd[39:0]};
  always_ff @(posedge clk)
  begin
    cpu_q <= (cmd.valid && sel == 2'h0) ? cmd : idle;
    dma_q <= (cmd.valid && sel == 2'h1) ? cmd : idle;
    dtc_q <= (cmd.valid && sel == 2'h2) ? cmd : idle;
    eth_q <= (cmd.valid && sel == 2'h3) ? {cmd[40:39], 1'b1, cmd[37:0]} : idle;
  end
endmodule // saf_tb_master

// *** test/tb.sv ***
// tb: register-bus and side-port sequences for the access filter
// assumes: one clock, ce tied high, extension strap driven by the bench
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb
  import saf_pkg::*;
;
  logic clk = 0, rstn = 0, lifecycle_ssd = 0, cpu_to_ns = 0, cpu_to_s = 0;
  logic pe_entry_req = 0, pe_entry_ns = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic dma_start_req = 0, dma_start_ns = 0, dma_start_ok, sec_ext = 1;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic prog_done, prog_refused, cpu_secure, transfer_error_irq, pe_entry_ok;
  logic secure_fault_rst, secure_fault_nmi, per_allow, per_access_error;
  logic [2:0] prot = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, per_rdata_in = 0, rdata, per_rdata, rd;
  logic [1:0] sel = 0, bresp, rresp, rs;
  logic [3:0] bmpu_attr;
  saf_prog_type prog_cmd = '0;
  saf_req_type cmd = '0, per_req = '0, cpu_req, dma_req, dtc_req, eth_req;
  saf_ans_type cpu_ans, dma_ans, dtc_ans, eth_ans;
  int error_cnt = 0, n_compared = 0;
  always #50 clk = ~clk;
  saf_tb_master u_mst (.clk, .cmd, .sel, .cpu_q(cpu_req), .dma_q(dma_req),
    .dtc_q(dtc_req), .eth_q(eth_req));
  saf_top u_dut (.clk, .rstn, .ce(1'b1), .sec_ext_present(sec_ext), .lifecycle_ssd,
    .cpu_to_ns, .cpu_to_s, .prog_cmd, .cpu_req, .dma_req, .dtc_req, .eth_req,
    .dma_start_req, .dma_start_ns, .pe_entry_req, .pe_entry_ns, .per_req,
    .per_rdata_in, .prog_done, .prog_refused, .cpu_secure, .cpu_ans, .dma_ans, .dtc_ans,
    .eth_ans, .dma_start_ok, .transfer_error_irq, .pe_entry_ok, .secure_fault_rst,
    .secure_fault_nmi, .per_allow, .per_access_error, .per_rdata, .bmpu_attr, .awaddr,
    .awprot(prot), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arprot(prot), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  task give_verdict;
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task hang(input logic ok);
    if (!ok)
    begin
      error_cnt++;
      $display("[ERR] handshake exp 1 got 0");
      give_verdict();
    end
  endtask
  // --------------------------------------------------------------
  // bus and side-port tasks
  // --------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d, input logic ns);
    @(posedge clk);
    awaddr <= a; wdata <= d; prot <= {1'b0, ns, 1'b0};
    awvalid <= 1; wvalid <= 1; bready <= 1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    hang(bvalid);
    rs = bresp; bready <= 0;
    #1;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; prot <= 3'h0; arvalid <= 1; rready <= 1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    hang(rvalid);
    rd = rdata; rs = rresp; rready <= 0;
  endtask
  task side(input logic w, input logic ns, input logic [4:0] ch, input logic [31:0] a,
    input logic [1:0] s);
    @(posedge clk);
    cmd <= '{1'b1, w, ns, ch, 1'b0, a}; sel <= s;
    @(posedge clk);
    cmd.valid <= 0;
    @(posedge clk);
    #1;
  endtask
  task pr(input logic ns, input logic [4:0] ch, input logic fine);
    @(posedge clk);
    per_req <= '{1'b1, 1'b0, ns, ch, fine, 32'h0};
    @(posedge clk);
    per_req.valid <= 0;
    #1;
  endtask
  task pe(input logic ns);
    @(posedge clk);
    pe_entry_req <= 1; pe_entry_ns <= ns; dma_start_req <= 1; dma_start_ns <= ns;
    @(posedge clk);
    pe_entry_req <= 0; dma_start_req <= 0;
    #1;
  endtask
  task prg(input logic [2:0] ix, input logic [31:0] b, input logic [31:0] l, input saf_attr_type t);
    @(posedge clk);
    prog_cmd <= '{1'b1, ix, '{b, l, t}};
    @(posedge clk);
    prog_cmd.valid <= 0;
    #1;
  endtask
  task flip(input logic ns);
    @(posedge clk);
    cpu_to_ns <= ns; cpu_to_s <= !ns;
    @(posedge clk);
    cpu_to_ns <= 0; cpu_to_s <= 0;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    repeat (4) @(posedge clk);
    `CHK("cpu_secure", 1'b1, cpu_secure)
    rdr(8'h00); `CHK("ctrl", 32'h0, rd)
    pe(1); `CHK("pe_ns", 1'b0, pe_entry_ok)
    `CHK("start_ns", 1'b0, dma_start_ok)
    rdr(8'h04); `CHK("pe_err", 1'b1, rd[0])
    pe(0); `CHK("pe_s", 1'b1, pe_entry_ok)
    `CHK("start_s", 1'b1, dma_start_ok)
    wr(8'h00, 32'h1, 1); `CHK("ctrl_ns", 2'h2, rs)
    wr(8'h00, 32'h1, 0); pe(1); `CHK("pe_both", 1'b1, pe_entry_ok)
    wr(8'h40, 32'h0, 0); `CHK("unmapped", 2'h3, rs)
    wr(8'h10, 32'h5, 1); `CHK("bmpu_ns", 2'h2, rs)
    wr(8'h10, 32'h5, 0); `CHK("bmpu", 4'h5, bmpu_attr)
    prg(0, 32'h1000, 32'h1fff, SAF_ATTR_S); `CHK("refused", 1'b1, prog_refused)
    lifecycle_ssd <= 1;
    prg(0, 32'h1000, 32'h1fff, SAF_ATTR_S); `CHK("prog", 1'b1, prog_done)
    prg(1, 32'h2000, 32'h2fff, SAF_ATTR_NSC); `CHK("prog1", 1'b1, prog_done)
    side(0, 0, 0, 32'h1000, 1); `CHK("dma_deny", 1'b1, dma_ans.deny)
    `CHK("irq", 1'b1, transfer_error_irq)
    side(0, 0, 0, 32'h3000, 1); `CHK("dma_ok", 1'b1, dma_ans.grant)
    wr(8'h08, 32'h8, 0); side(0, 0, 3, 32'h1000, 1); `CHK("dma_ch3", 1'b1, dma_ans.grant)
    side(0, 1, 0, 32'h2000, 2); `CHK("dtc_ns", 1'b1, dtc_ans.deny)
    side(0, 0, 0, 32'h2000, 2); `CHK("dtc_s", 1'b1, dtc_ans.grant)
    side(0, 0, 0, 32'h1000, 3); `CHK("eth", 1'b1, eth_ans.deny)
    rdr(8'h04); `CHK("filter_err", 1'b1, rd[1])
    side(0, 0, 0, 32'h1000, 0); `CHK("cpu_s", 1'b1, cpu_ans.grant)
    flip(1); side(0, 0, 0, 32'h1000, 0); `CHK("cpu_ns", 1'b1, cpu_ans.deny)
    `CHK("fault_rst", 1'b1, secure_fault_rst)
    side(1, 0, 0, 32'h2004, 0); `CHK("sram_wr", 1'b1, cpu_ans.deny)
    `CHK("sram_fault", 1'b1, secure_fault_rst)
    wr(8'h00, 32'h2, 0); side(0, 0, 0, 32'h1000, 0); `CHK("nmi", 1'b1, secure_fault_nmi)
    flip(0); side(0, 0, 0, 32'h1000, 0); `CHK("cpu_back", 1'b1, cpu_ans.grant)
    wr(8'h0c, 32'h10000004, 0); rdr(8'h0c); `CHK("per_attr", 32'h4, rd)
    per_rdata_in <= 32'ha5;
    pr(1, 2, 0); `CHK("per_err", 1'b1, per_access_error)
    `CHK("per_zero", 32'h0, per_rdata)
    pr(0, 2, 0); `CHK("per_data", 32'ha5, per_rdata)
    pr(1, 3, 0); `CHK("per_ch3", 1'b1, per_allow)
    wr(8'h14, 32'h2, 0); pr(1, 1, 1); `CHK("fine", 1'b1, per_access_error)
    pr(1, 0, 1); `CHK("fine0", 1'b1, per_allow)
    rstn <= 0; sec_ext <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    repeat (4) @(posedge clk);
    flip(0); #1 `CHK("no_ext", 1'b0, cpu_secure)
    give_verdict();
  end
endmodule // tb
bind saf_top saf_top_checker u_chk (.clk, .rstn, .sec_ext_present, .cpu_secure, .dma_req,
  .dma_ans, .eth_req, .eth_ans, .transfer_error_irq, .pe_entry_req, .pe_entry_ns,
  .pe_entry_ok, .per_req, .per_allow, .per_access_error, .per_rdata);
